//--- hw/aid_core.sv
// ata drive-side command logic: identify words 82-131, init drive parameters, recalibrate
// assumes an axi4-lite master on sys_clk and a servo that answers a seek request on async pins
// How it works
// RL1 - identify word 83 bit 9 reports automatic acoustic management support from configuration.
// RL2 - words 82/83 can never both read all zeros or all ones, since 83 carries fixed bits 15=0 and 14=1.
// RL3 - identify word 84 reads bit 15 zero, bit 14 one and bits 13 to 0 zero.
// RL4 - identify word 85 shows the enabled features from the enable register, with bits 15 and 11 held at zero.
// RL5 - word 88 bits 13 to 8 one-hot mark the selected ultra dma mode 5 down to 0.
// RL6 - word 88 bits 5 to 0 form a thermometer: bit n set means mode n and all below supported.
// RL7 - word 128 carries security level, count expired, frozen, locked, enabled and supported.
// RL8 - word 131 bit 0 reads zero while the no-spin-at-power-up option is on.
// RL9 - init params takes sectors per track from sector count, max head from drive/head, computes cylinders.
// RL10 - init params raises busy, stores geometry, drops busy, then raises the interrupt.
// RL11 - the host writes heads minus one and the true sectors per track.
// RL12 - the supplied geometry is never checked, so init params never reports an error.
// RL13 - a cylinder count above 65535 is clamped to 65535.
// RL14 - recalibrate raises busy and starts a seek to cylinder zero.
// RL15 - recalibrate waits for the seek, updates status, drops busy, then raises the interrupt.
// RL16 - a failed recalibrate sets the status error bit and the track-zero-not-found error bit.
// RL17 - the host loads the task registers first and waits for busy to drop before a new command.
`timescale 1ns/1ps
`default_nettype none
module aid_core
  import aid_pkg::*;
#(
  parameter logic [31:0] TOTAL_SECTORS = TOTAL_SECT
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // servo seek handshake, answers are asynchronous
  output logic             seekStart,
  input  wire logic        seekDone,
  input  wire logic        seekFail,
  // interrupt
  output logic             irq
);

  // whole block state in one record
  typedef struct packed {
    aid_state_t  st;
    logic [7:0]  secCnt;
    logic [7:0]  drvHead;
    logic [7:0]  cmd;
    logic        errBit;
    logic        dscBit;
    logic [7:0]  errReg;
    logic [2:0]  intStat;
    logic [2:0]  intMask;
    logic [15:0] cylCnt;
    logic [3:0]  maxHead;
    logic [7:0]  spt;
    logic [11:0] rem;
    logic [31:0] quo;
    logic [11:0] dvsr;
    logic [5:0]  divCnt;
    logic        seekStart;
    logic        seekErr;
    logic        doneS1;
    logic        doneS2;
    logic        failS1;
    logic        failS2;
    logic [31:0] featSup;
    logic [15:0] featEn;
    logic [7:0]  udmaCfg;
    logic [8:0]  secCfg;
    logic        noSpin;
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } aid_regs_t;

  aid_regs_t r_r;
  aid_regs_t r_nxt;

  // low byte lane update, other lanes of small registers read as zero
  function automatic logic [7:0] upd8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    upd8 = s[0] ? d[7:0] : old;
  endfunction

  // full word update honouring every byte strobe
  function automatic logic [31:0] upd32(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      upd32[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // modes above 5 do not exist, so they fold onto mode 5
  function automatic logic [2:0] clampMode(input logic [2:0] m);
    clampMode = (m > 3'h5) ? 3'h5 : m;
  endfunction

  // supported set: the chosen mode and everything below it
  function automatic logic [5:0] udmaThermo(input logic en, input logic [2:0] m);
    udmaThermo = en ? 6'(7'h7F >> (3'h6 - clampMode(m))) : 6'h00;
  endfunction

  // selected mode is exactly one bit
  function automatic logic [5:0] udmaOneHot(input logic en, input logic [2:0] m);
    udmaOneHot = en ? 6'(7'h01 << clampMode(m)) : 6'h00;
  endfunction

  // word-aligned decode, the two low address bits are ignored
  function automatic logic [7:0] alignAddr(input logic [7:0] a);
    alignAddr = {a[7:2], 2'h0};
  endfunction

  // identify words built from live configuration
  logic [15:0] idW82;
  logic [15:0] idW83;
  logic [15:0] idW84;
  logic [15:0] idW85;
  logic [15:0] idW88;
  logic [15:0] idW128;
  logic [15:0] idW131;
  logic        busy;
  logic [7:0]  statByte;

  always_comb begin
    // word 82 bit 4 is fixed at zero
    idW82  = r_r.featSup[15:0] & 16'hFFEF;
    // RL1 aam support bit
    // RL2 fixed top bits keep notification valid
    idW83  = {2'h1, r_r.featSup[29:16]};
    // RL3 fixed extension word
    idW84  = 16'h4000;
    // RL4 enabled feature bits
    idW85  = {1'h0, r_r.featEn[14:12], 1'h0, r_r.featEn[10:0]};
    // RL5 selected mode one-hot
    // RL6 supported mode thermometer
    idW88  = {2'h0, udmaOneHot(r_r.udmaCfg[7], r_r.udmaCfg[6:4]),
              2'h0, udmaThermo(r_r.udmaCfg[3], r_r.udmaCfg[2:0])};
    // RL7 security status
    idW128 = {7'h00, r_r.secCfg[8], 3'h0, r_r.secCfg[4:0]};
    // RL8 spin-up option
    idW131 = {15'h0000, ~r_r.noSpin};
  end

  // busy covers the whole execution, it drops one cycle before the interrupt bit rises
  assign busy = (r_r.st == ST_IP_DIV) || (r_r.st == ST_RC_SEEK) || (r_r.st == ST_RC_UPD);

  always_comb begin
    statByte = 8'h00;
    statByte[ST_BSY]  = busy;
    statByte[ST_DRDY] = 1'b1;
    statByte[ST_DSC]  = r_r.dscBit;
    statByte[ST_ERR]  = r_r.errBit;
  end

  // handshake outputs are combinational from state, data outputs straight from flops
  assign s_axi_awready = !r_r.awHeld;
  assign s_axi_wready  = !r_r.wHeld;
  assign s_axi_arready = !r_r.rvalid;
  assign s_axi_bvalid  = r_r.bvalid;
  assign s_axi_bresp   = r_r.bresp;
  assign s_axi_rvalid  = r_r.rvalid;
  assign s_axi_rresp   = r_r.rresp;
  assign s_axi_rdata   = r_r.rdata;
  assign seekStart     = r_r.seekStart;
  assign irq           = |(r_r.intStat & r_r.intMask);

  // next-state logic for the whole block
  always_comb begin
    logic        cmdWr;
    logic [12:0] trial;
    logic [11:0] newRem;
    logic [31:0] newQuo;
    cmdWr  = 1'b0;
    trial  = 13'h0000;
    newRem = 12'h000;
    newQuo = 32'h0000_0000;
    r_nxt  = r_r;
    r_nxt.seekStart = 1'b0;

    // two-flop synchronisers for the servo answers
    r_nxt.doneS1 = seekDone;
    r_nxt.doneS2 = r_r.doneS1;
    r_nxt.failS1 = seekFail;
    r_nxt.failS2 = r_r.failS1;

    // address and data are taken in either order and held until both are present
    if (s_axi_awvalid && !r_r.awHeld) begin
      r_nxt.awHeld = 1'b1;
      r_nxt.awAddr = alignAddr(s_axi_awaddr);
    end
    if (s_axi_wvalid && !r_r.wHeld) begin
      r_nxt.wHeld = 1'b1;
      r_nxt.wData = s_axi_wdata;
      r_nxt.wStrb = s_axi_wstrb;
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end

    // write executes one cycle after both halves are held, one response at a time
    if (r_r.awHeld && r_r.wHeld && !r_r.bvalid) begin
      r_nxt.awHeld = 1'b0;
      r_nxt.wHeld  = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = RESP_OKAY;
      case (r_r.awAddr)
        ADDR_SECCNT:  r_nxt.secCnt = upd8(r_r.secCnt, r_r.wData, r_r.wStrb);
        ADDR_DRVHEAD: r_nxt.drvHead = upd8(r_r.drvHead, r_r.wData, r_r.wStrb);
        ADDR_COMMAND: cmdWr = r_r.wStrb[0];
        ADDR_INTMASK: r_nxt.intMask = r_r.wStrb[0] ? r_r.wData[2:0] : r_r.intMask;
        ADDR_FEATSUP: r_nxt.featSup = upd32(r_r.featSup, r_r.wData, r_r.wStrb);
        ADDR_FEATEN:  r_nxt.featEn = 16'(upd32({16'h0000, r_r.featEn}, r_r.wData, r_r.wStrb));
        ADDR_UDMACFG: r_nxt.udmaCfg = upd8(r_r.udmaCfg, r_r.wData, r_r.wStrb);
        ADDR_SECCFG:  r_nxt.secCfg = 9'(upd32({23'h000000, r_r.secCfg}, r_r.wData, r_r.wStrb));
        ADDR_SPINCFG: r_nxt.noSpin = r_r.wStrb[0] ? r_r.wData[0] : r_r.noSpin;
        // read-only registers swallow writes quietly
        ADDR_STATUS, ADDR_ERROR, ADDR_INTSTAT, ADDR_GEOMCYL, ADDR_GEOMHS,
        ADDR_ID82, ADDR_ID84, ADDR_ID88, ADDR_ID131: r_nxt.bresp = RESP_OKAY;
        default:      r_nxt.bresp = RESP_SLVERR;
      endcase
    end

    // read answers one cycle after the address, reading the interrupt status clears it
    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r_r.rvalid) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp  = RESP_OKAY;
      r_nxt.rdata  = 32'h0000_0000;
      case (alignAddr(s_axi_araddr))
        ADDR_SECCNT:  r_nxt.rdata[7:0] = r_r.secCnt;
        ADDR_DRVHEAD: r_nxt.rdata[7:0] = r_r.drvHead;
        ADDR_COMMAND: r_nxt.rdata[7:0] = r_r.cmd;
        ADDR_STATUS:  r_nxt.rdata[7:0] = statByte;
        ADDR_ERROR:   r_nxt.rdata[7:0] = r_r.errReg;
        ADDR_INTSTAT: begin
          r_nxt.rdata[2:0] = r_r.intStat;
          r_nxt.intStat    = 3'h0;
        end
        ADDR_INTMASK: r_nxt.rdata[2:0] = r_r.intMask;
        ADDR_GEOMCYL: r_nxt.rdata[15:0] = r_r.cylCnt;
        ADDR_GEOMHS:  r_nxt.rdata = {12'h000, r_r.maxHead, 8'h00, r_r.spt};
        ADDR_FEATSUP: r_nxt.rdata = r_r.featSup;
        ADDR_FEATEN:  r_nxt.rdata[15:0] = r_r.featEn;
        ADDR_UDMACFG: r_nxt.rdata[7:0] = r_r.udmaCfg;
        ADDR_SECCFG:  r_nxt.rdata[8:0] = r_r.secCfg;
        ADDR_SPINCFG: r_nxt.rdata[0] = r_r.noSpin;
        ADDR_ID82:    r_nxt.rdata = {idW83, idW82};
        ADDR_ID84:    r_nxt.rdata = {idW85, idW84};
        ADDR_ID88:    r_nxt.rdata = {idW128, idW88};
        ADDR_ID131:   r_nxt.rdata[15:0] = idW131;
        default:      r_nxt.rresp = RESP_SLVERR;
      endcase
    end

    // command sequencer; event bits are set after the read clear so a set wins
    case (r_r.st)
      ST_IDLE: begin
        // commands outside idle are dropped, the host must wait for busy to fall
        if (cmdWr) begin
          r_nxt.cmd    = r_r.wData[7:0];
          r_nxt.errBit = 1'b0;
          r_nxt.errReg = 8'h00;
          if (r_r.wData[7:0] == CMD_INITPARAM) begin
            // RL9 latch translated geometry
            r_nxt.spt     = r_r.secCnt;
            r_nxt.maxHead = r_r.drvHead[3:0];
            r_nxt.dvsr    = 12'(({1'h0, r_r.drvHead[3:0]} + 5'h01) * r_r.secCnt);
            r_nxt.rem     = 12'h000;
            r_nxt.quo     = TOTAL_SECTORS;
            r_nxt.divCnt  = DIV_STEPS;
            // RL10 busy rises next cycle
            r_nxt.st      = ST_IP_DIV;
          end else if (r_r.wData[7:0] == CMD_RECAL) begin
            // RL14 busy and seek to cylinder zero
            r_nxt.seekStart = 1'b1;
            r_nxt.dscBit    = 1'b0;
            r_nxt.st        = ST_RC_SEEK;
          end else begin
            // unknown codes abort at once
            r_nxt.errBit          = 1'b1;
            r_nxt.errReg[ER_ABRT] = 1'b1;
            r_nxt.st              = ST_AB_END;
          end
        end
      end
      ST_IP_DIV: begin
        // one restoring divide step a cycle; a zero divisor yields all ones and so clamps
        trial  = {r_r.rem, r_r.quo[31]};
        newQuo = {r_r.quo[30:0], 1'b0};
        newRem = trial[11:0];
        if (trial >= {1'h0, r_r.dvsr}) begin
          newRem    = 12'(trial - {1'h0, r_r.dvsr});
          newQuo[0] = 1'b1;
        end
        r_nxt.rem    = newRem;
        r_nxt.quo    = newQuo;
        r_nxt.divCnt = r_r.divCnt - 6'h01;
        if (r_r.divCnt == 6'h01) begin
          // RL12 no validity check, never an error
          // RL13 clamp to the cylinder limit
          r_nxt.cylCnt = (newQuo[31:16] != 16'h0000) ? CYL_LIMIT : newQuo[15:0];
          r_nxt.st     = ST_IP_END;
        end
      end
      ST_IP_END: begin
        // RL10 interrupt after busy fell
        r_nxt.intStat[INT_INIT] = 1'b1;
        r_nxt.st                = ST_IDLE;
      end
      ST_RC_SEEK: begin
        // RL15 wait for the seek, then settle status while busy still stands
        if (r_r.doneS2 || r_r.failS2) begin
          r_nxt.seekErr = r_r.failS2;
          // RL16 track zero not reached
          if (r_r.failS2) begin
            r_nxt.errBit           = 1'b1;
            r_nxt.errReg[ER_TK0NF] = 1'b1;
          end else begin
            r_nxt.dscBit = 1'b1;
          end
          r_nxt.st = ST_RC_UPD;
        end
      end
      ST_RC_UPD: begin
        // RL15 busy falls one cycle after status is settled
        r_nxt.st = ST_RC_END;
      end
      ST_RC_END: begin
        // RL15 interrupt after busy fell
        r_nxt.intStat[INT_RECAL] = 1'b1;
        r_nxt.st                 = ST_IDLE;
      end
      ST_AB_END: begin
        r_nxt.intStat[INT_ABORT] = 1'b1;
        r_nxt.st                 = ST_IDLE;
      end
      default: r_nxt.st = ST_IDLE;
    endcase
  end

  // state register; constants only under reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r_r         <= '0;
      r_r.st      <= ST_IDLE;
      r_r.featSup <= FEATSUP_RST;
      r_r.featEn  <= FEATEN_RST;
      r_r.udmaCfg <= UDMACFG_RST;
      r_r.secCfg  <= SECCFG_RST;
      r_r.noSpin  <= NOSPIN_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // helper: a command accepted this cycle
  logic takeInit;
  logic takeRecal;
  assign takeInit  = (r_r.st == ST_IDLE) && r_r.awHeld && r_r.wHeld && !r_r.bvalid &&
                     (r_r.awAddr == ADDR_COMMAND) && r_r.wStrb[0] && (r_r.wData[7:0] == CMD_INITPARAM);
  assign takeRecal = (r_r.st == ST_IDLE) && r_r.awHeld && r_r.wHeld && !r_r.bvalid &&
                     (r_r.awAddr == ADDR_COMMAND) && r_r.wStrb[0] && (r_r.wData[7:0] == CMD_RECAL);

  notify_valid_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL2
    !(({idW83, idW82} == 32'h0000_0000) || ({idW83, idW82} == 32'hFFFF_FFFF)))
    else $error("identify words 82 and 83 hide notification");

  ext_word_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL3
    idW84[15:14] == 2'h1 && idW84[13:0] == 14'h0000)
    else $error("identify word 84 fixed bits wrong");

  udma_thermo_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL6
    ((idW88[5:0] + 6'h01) & idW88[5:0]) == 6'h00 && $onehot0(idW88[13:8]))
    else $error("identify word 88 mode bits malformed");

  init_busy_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL10
    takeInit |=> busy [*8] ##25 !busy ##0 (r_r.st == ST_IP_END) ##1 r_r.intStat[INT_INIT])
    else $error("init params busy and interrupt order wrong");

  cyl_clamp_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL13
    (r_r.st == ST_IP_END) |-> (r_r.quo[31:16] != 16'h0000 ? r_r.cylCnt == CYL_LIMIT : r_r.cylCnt == r_r.quo[15:0]))
    else $error("cylinder count not clamped");

  recal_start_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL14
    takeRecal |=> seekStart && busy ##1 !seekStart)
    else $error("recalibrate did not start a seek");

  recal_fail_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL16
    (r_r.st == ST_RC_UPD && r_r.seekErr) |-> r_r.errBit && r_r.errReg[ER_TK0NF] && busy ##1 !busy)
    else $error("recalibrate failure not reported");

  recal_end_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL15
    (r_r.st == ST_RC_SEEK && r_r.doneS2) |=> busy && (r_r.dscBit || r_r.errBit) ##1 !busy ##1 r_r.intStat[INT_RECAL])
    else $error("recalibrate completion order wrong");

endmodule
`default_nettype wire

//--- hw/aid_pkg.sv
// constants, register map and state layout of the ata identify / init-params / recalibrate block
// assumes a single 40 MHz device clock and an axi4-lite register port with 8-bit byte addresses
package aid_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] ADDR_SECCNT   = 8'h00;
  localparam logic [7:0] ADDR_DRVHEAD  = 8'h04;
  localparam logic [7:0] ADDR_COMMAND  = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_ERROR    = 8'h10;
  localparam logic [7:0] ADDR_INTSTAT  = 8'h14;
  localparam logic [7:0] ADDR_INTMASK  = 8'h18;
  localparam logic [7:0] ADDR_GEOMCYL  = 8'h1C;
  localparam logic [7:0] ADDR_GEOMHS   = 8'h20;
  localparam logic [7:0] ADDR_FEATSUP  = 8'h24;
  localparam logic [7:0] ADDR_FEATEN   = 8'h28;
  localparam logic [7:0] ADDR_UDMACFG  = 8'h2C;
  localparam logic [7:0] ADDR_SECCFG   = 8'h30;
  localparam logic [7:0] ADDR_SPINCFG  = 8'h34;
  localparam logic [7:0] ADDR_ID82     = 8'h38;
  localparam logic [7:0] ADDR_ID84     = 8'h3C;
  localparam logic [7:0] ADDR_ID88     = 8'h40;
  localparam logic [7:0] ADDR_ID131    = 8'h44;

  // command codes
  localparam logic [7:0] CMD_INITPARAM = 8'h91;
  localparam logic [7:0] CMD_RECAL     = 8'h10;

  // status, error and interrupt bit positions
  localparam int ST_BSY    = 7;
  localparam int ST_DRDY   = 6;
  localparam int ST_DSC    = 4;
  localparam int ST_ERR    = 0;
  localparam int ER_ABRT   = 2;
  localparam int ER_TK0NF  = 1;
  localparam int INT_INIT  = 0;
  localparam int INT_RECAL = 1;
  localparam int INT_ABORT = 2;

  // axi responses, geometry limits, divider length
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  localparam logic [15:0] CYL_LIMIT    = 16'hFFFF;
  localparam logic [5:0]  DIV_STEPS    = 6'h20;
  localparam logic [31:0] TOTAL_SECT   = 32'h0262_4000;

  // reset values of the software-set identify configuration
  localparam logic [31:0] FEATSUP_RST  = 32'h0000_0000;
  localparam logic [15:0] FEATEN_RST   = 16'h0000;
  localparam logic [7:0]  UDMACFG_RST  = 8'h0D;
  localparam logic [8:0]  SECCFG_RST   = 9'h000;
  localparam logic        NOSPIN_RST   = 1'b0;

  // command sequencer, gray along each command path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_IP_DIV = 3'h1,
    ST_IP_END = 3'h3,
    ST_AB_END = 3'h2,
    ST_RC_SEEK = 3'h4,
    ST_RC_UPD = 3'h5,
    ST_RC_END = 3'h7
  } aid_state_t;

endpackage

//--- sim/aid_servo_model.sv
// behavioural servo that answers the block's seek-to-cylinder-zero request
// assumes seekStart is a one-cycle pulse on sys_clk; answers are held for several cycles
`timescale 1ns/1ps
`default_nettype none
module aid_servo_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // scenario control
  input  wire logic failMode,
  input  wire logic slowMode,
  // seek handshake
  input  wire logic seekStart,
  output logic      seekDone,
  output logic      seekFail
);
  int cnt;
  // answer after 2 or 40 cycles, hold 10 so the two-stage sync surely sees it
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      seekDone <= 1'b0;
      seekFail <= 1'b0;
    end else if (seekStart) begin
      cnt <= 1;
    end else if (cnt != 0) begin
      cnt <= cnt + 1;
      if (cnt == (slowMode ? 40 : 2)) begin
        seekDone <= 1'b1;
        seekFail <= failMode;
      end
      if (cnt == (slowMode ? 50 : 12)) begin
        cnt <= 0;
        seekDone <= 1'b0;
        seekFail <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the identify / init-params / recalibrate block
// assumes the design package and core are compiled first; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aid_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wrResp, rdResp;
  logic [31:0] rdVal;
  logic        seekStart, seekDone, seekFail, irq;
  logic        failMode = 1'b0, slowMode = 1'b0;
  int          error_cnt = 0, checks_done = 0, cycleCnt = 0, startCnt = 0;

  aid_core #(.TOTAL_SECTORS(32'h0003_0D40)) u_aid_core (
    .sys_clk(sys_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .seekStart(seekStart), .seekDone(seekDone), .seekFail(seekFail), .irq(irq));
  aid_servo_model u_aid_servo_model (
    .sys_clk(sys_clk), .nrst(nrst), .failMode(failMode), .slowMode(slowMode),
    .seekStart(seekStart), .seekDone(seekDone), .seekFail(seekFail));

  // clock, seek-pulse count and hang guard (a full run needs well under 3000 cycles)
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycleCnt++;
    if (seekStart === 1'b1) startCnt++;
    if (cycleCnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  // one write; each channel released on its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed: only the bench timeout ends this wait
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wrResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk($sformatf("reg %h", a), e, rdVal);
  endtask

  // a missing interrupt is caught by the bench timeout
  task automatic wait_irq();
    while (irq !== 1'b1) begin
      @(posedge sys_clk);
    end
  endtask

  // identify words from configuration, plus an unmapped access
  task automatic t_ident();
    rc(ADDR_UDMACFG, 32'h0000_000D);
    rc(ADDR_ID84, 32'h0000_4000);
    axw(ADDR_FEATSUP, 32'h0200_0010);
    rc(ADDR_ID82, 32'h4200_0000);
    axw(ADDR_FEATEN, 32'h0000_FFFF);
    rc(ADDR_ID84, 32'h77FF_4000);
    axw(ADDR_UDMACFG, 32'h0000_00BD);
    axw(ADDR_SECCFG, 32'h0000_011F);
    rc(ADDR_ID88, 32'h011F_083F);
    axw(ADDR_UDMACFG, 32'h0000_0088);
    rc(ADDR_ID88, 32'h011F_0101);
    axw(ADDR_SPINCFG, 32'h0000_0001);
    rc(ADDR_ID131, 32'h0000_0000);
    axw(ADDR_SPINCFG, 32'h0000_0000);
    rc(ADDR_ID131, 32'h0000_0001);
    axw(8'h48, 32'h0000_0001);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, wrResp});
    axr(8'h48);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rdResp});
  endtask

  // initialize-parameters with the given geometry
  task automatic t_init(input logic [7:0] sec, input logic [3:0] hd, input logic [15:0] cyl);
    axr(ADDR_INTSTAT);
    axw(ADDR_SECCNT, {24'h0, sec});
    axw(ADDR_DRVHEAD, {28'h0, hd});
    axw(ADDR_COMMAND, {24'h0, CMD_INITPARAM});
    axr(ADDR_STATUS);
    chk("busy", 32'h1, {31'h0, rdVal[ST_BSY]});
    chk("irq early", 32'h0, {31'h0, irq});
    wait_irq();
    rc(ADDR_STATUS, 32'h0000_0040);
    rc(ADDR_GEOMCYL, {16'h0, cyl});
    rc(ADDR_GEOMHS, {12'h0, hd, 8'h00, sec});
    rc(ADDR_INTSTAT, 32'h0000_0001);
    rc(ADDR_INTSTAT, 32'h0000_0000);
    chk("irq low", 32'h0, {31'h0, irq});
  endtask

  // recalibrate, the servo answering as told
  task automatic t_recal(input logic fl, input logic sl, input logic [31:0] st, input logic [31:0] er);
    int s0;
    failMode <= fl;
    slowMode <= sl;
    axr(ADDR_INTSTAT);
    s0 = startCnt;
    axw(ADDR_COMMAND, {24'h0, CMD_RECAL});
    if (sl) begin
      axr(ADDR_STATUS);
      chk("recal busy", 32'h1, {31'h0, rdVal[ST_BSY]});
    end
    wait_irq();
    chk("seek pulses", s0 + 1, startCnt);
    rc(ADDR_STATUS, st);
    rc(ADDR_ERROR, er);
    rc(ADDR_INTSTAT, 32'h0000_0002);
  endtask

  // unknown command with its interrupt masked off
  task automatic t_abort();
    axw(ADDR_INTMASK, 32'h0000_0000);
    axw(ADDR_COMMAND, 32'h0000_0055);
    rc(ADDR_STATUS, 32'h0000_0051);
    chk("masked irq", 32'h0, {31'h0, irq});
    rc(ADDR_ERROR, 32'h0000_0004);
    rc(ADDR_INTSTAT, 32'h0000_0004);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rc(ADDR_INTMASK, 32'h0000_0000);
    t_ident();
    axw(ADDR_INTMASK, 32'h0000_0007);
    t_init(8'h11, 4'h4, 16'h0930);
    t_init(8'h01, 4'h0, 16'hFFFF);
    t_init(8'h00, 4'hF, 16'hFFFF);
    t_recal(1'b1, 1'b0, 32'h0000_0041, 32'h0000_0002);
    t_recal(1'b0, 1'b1, 32'h0000_0050, 32'h0000_0000);
    t_abort();
    test_done();
  end
endmodule
`default_nettype wire
